// ==== bench/ccp_osc_model.sv ====
// Oscillators and PLL analog stand-ins at the far side of the clock block
`timescale 1ns/10ps
module ccp_osc_model #(
  parameter int IRC_H = 50,
  parameter int MAIN_H = 75,
  parameter int RTC_H = 125,
  parameter int CCO_H = 35
) (
  input wire logic main_pll_en,
  input wire logic usb_pll_en,
  output logic irc_osc,
  output logic main_osc,
  output logic rtc_osc,
  output logic main_cco,
  output logic usb_cco,
  output logic main_pll_lock,
  output logic usb_pll_lock
);
  initial begin
    irc_osc = 1'b0;
    main_osc = 1'b0;
    rtc_osc = 1'b0;
    main_cco = 1'b0;
    usb_cco = 1'b0;
    main_pll_lock = 1'b0;
    usb_pll_lock = 1'b0;
  end
  // Scaled rates keep the run short; only ratios between sources matter
  always #(IRC_H) irc_osc = ~irc_osc;
  always #(MAIN_H) main_osc = ~main_osc;
  always #(RTC_H) rtc_osc = ~rtc_osc;
  // A stopped oscillator rests low, never at a stale level
  always #(CCO_H) main_cco = main_pll_en ? ~main_cco : 1'b0;
  always #10.4 usb_cco = usb_pll_en ? ~usb_cco : 1'b0;
  // Lock only after a settling time, and lost at once on disable
  always begin
    wait (main_pll_en);
    #500 main_pll_lock = main_pll_en;
    wait (!main_pll_en);
    main_pll_lock = 1'b0;
  end
  always begin
    wait (usb_pll_en);
    #500 usb_pll_lock = usb_pll_en;
    wait (!usb_pll_en);
    usb_pll_lock = 1'b0;
  end
endmodule : ccp_osc_model

// ==== bench/clock_source_pll_control_tb.sv ====
// Self-checking bench of the clock source and PLL control block
`timescale 1ns/10ps
module clock_source_pll_control_tb;
  localparam int IRC_H = 50;
  localparam int MAIN_H = 75;
  localparam int RTC_H = 125;
  localparam int CCO_H = 35;
  logic mclk, sys_rst, ce, wr, rd, pd_entry;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, st;
  logic irc_osc, main_osc, rtc_osc, main_cco, usb_cco, main_pll_lock, usb_pll_lock;
  logic main_pll_en, main_pll_ref, usb_pll_en, usb_pll_ref, pll_input_clock;
  logic cpu_clock, usb_clock, wdt_clk, rtc_tick_clk, clk_out;
  logic [14:0] main_pll_mult;
  logic [ccp_pkg::NPER-1:0] periph_clk;
  logic [9:0] mon;
  int n_fail = 0;
  int n_tests = 0;
  assign mon = {main_pll_ref, usb_clock, periph_clk[1:0], usb_pll_ref, wdt_clk, rtc_tick_clk, clk_out, cpu_clock,
                pll_input_clock};

  ccp_top #(.RTC_DIV(16'h0004)) i_ccp_top (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irc_osc(irc_osc), .main_osc(main_osc),
    .rtc_osc(rtc_osc), .main_cco(main_cco), .usb_cco(usb_cco), .main_pll_lock(main_pll_lock),
    .usb_pll_lock(usb_pll_lock), .pd_entry(pd_entry), .main_pll_en(main_pll_en),
    .main_pll_mult(main_pll_mult), .main_pll_ref(main_pll_ref), .usb_pll_en(usb_pll_en),
    .usb_pll_ref(usb_pll_ref), .pll_input_clock(pll_input_clock), .cpu_clock(cpu_clock),
    .usb_clock(usb_clock), .wdt_clk(wdt_clk), .rtc_tick_clk(rtc_tick_clk), .clk_out(clk_out),
    .periph_clk(periph_clk));
  ccp_osc_model #(.IRC_H(IRC_H), .MAIN_H(MAIN_H), .RTC_H(RTC_H), .CCO_H(CCO_H)) i_ccp_osc_model (
    .main_pll_en(main_pll_en), .usb_pll_en(usb_pll_en), .irc_osc(irc_osc), .main_osc(main_osc),
    .rtc_osc(rtc_osc), .main_cco(main_cco), .usb_cco(usb_cco), .main_pll_lock(main_pll_lock),
    .usb_pll_lock(usb_pll_lock));

  task close_out;
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    // Registers are updated by the strobe edge; return one edge later so callers see them
    @(posedge mclk);
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg

  // Counts rising edges of one monitored clock; sampling at mclk allows a little slack
  task near(input int k, input int n, input int h);
    int c, e;
    logic p;
    c = 0;
    p = 1'b0;
    e = n * 25 / (2 * h);
    repeat (n) begin
      @(posedge mclk);
      if (mon[k] === 1'b1 && p === 1'b0) c++;
      p = mon[k];
    end
    check({31'h0, c >= e - 2 && c <= e + 2}, 32'h1);
  endtask : near

  task t_reset;
    check({31'h0, main_pll_en}, 32'h0);
    check({31'h0, usb_pll_en}, 32'h0);
    rd_reg(ccp_pkg::ADDR_STATUS, st);
    check(st, 32'h0);
    near(1, 240, IRC_H);
  endtask : t_reset

  // A write while the clock enable is low must be lost
  task t_ce;
    ce <= 1'b0;
    wr_reg(ccp_pkg::ADDR_SRC, 32'h1);
    ce <= 1'b1;
    rd_reg(ccp_pkg::ADDR_SRC, st);
    check(st, 32'h0);
  endtask : t_ce

  task t_sources;
    int h[3];
    h = '{IRC_H, MAIN_H, RTC_H};
    for (int s = 0; s < 3; s++) begin
      wr_reg(ccp_pkg::ADDR_SRC, {29'h0, s == 2, 2'(s)});
      repeat (20) @(posedge mclk);
      near(0, 240, h[s]);
      near(1, 240, h[s]);
      near(4, 240, s == 2 ? RTC_H : IRC_H);
    end
    wr_reg(ccp_pkg::ADDR_SRC, 32'h0);
  endtask : t_sources

  task t_pll;
    wr_reg(ccp_pkg::ADDR_PLL_CFG, {9'h0, 15'h7fff, 8'hff});
    check({17'h0, main_pll_mult}, 32'h7fff);
    rd_reg(ccp_pkg::ADDR_PLL_CFG, st);
    check(st, {9'h0, 15'h7fff, 8'hff});
    // The RC input lies inside the PLL input range; configure first, then enable
    wr_reg(ccp_pkg::ADDR_PLL_CTRL, 32'h1);
    check({31'h0, main_pll_en}, 32'h1);
    st = 32'h0;
    for (int i = 0; i < 100 && st[0] !== 1'b1; i++) rd_reg(ccp_pkg::ADDR_STATUS, st);
    check(st & 32'h7, 32'h3);
    near(1, 240, IRC_H);
    near(8, 240, 6 * CCO_H);
    wr_reg(ccp_pkg::ADDR_PLL_CFG, 32'h1);
    near(9, 240, 2 * IRC_H);
    wr_reg(ccp_pkg::ADDR_CPU_DIV, 32'h1);
    // Connect only after lock was seen
    wr_reg(ccp_pkg::ADDR_PLL_CTRL, 32'h3);
    repeat (10) @(posedge mclk);
    near(1, 240, 2 * CCO_H);
    rd_reg(ccp_pkg::ADDR_STATUS, st);
    check(st & 32'h47, 32'h7);
    pd_entry <= 1'b1;
    repeat (6) @(posedge mclk);
    check({31'h0, main_pll_en}, 32'h0);
    pd_entry <= 1'b0;
    repeat (6) @(posedge mclk);
    check({31'h0, main_pll_en}, 32'h0);
    near(1, 240, IRC_H);
  endtask : t_pll

  task t_usb;
    wr_reg(ccp_pkg::ADDR_USB_CTRL, 32'h1);
    check({31'h0, usb_pll_en}, 32'h1);
    near(5, 240, MAIN_H);
    rd_reg(8'hfc, st);
    check(st, 32'h0);
  endtask : t_usb

  task t_out;
    int h[4];
    h = '{IRC_H, IRC_H, MAIN_H, RTC_H};
    for (int s = 0; s < 4; s++) begin
      wr_reg(ccp_pkg::ADDR_CLKOUT, 32'h8 | s);
      repeat (10) @(posedge mclk);
      near(2, 240, h[s]);
    end
    wr_reg(ccp_pkg::ADDR_PCLK, 32'h4);
    repeat (10) @(posedge mclk);
    near(7, 240, 2 * IRC_H);
    near(6, 240, IRC_H);
    near(3, 800, 4 * RTC_H);
  endtask : t_out

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #1ms;
    n_fail++;
    close_out;
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    pd_entry = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge mclk);
    t_reset;
    t_ce;
    t_sources;
    t_pll;
    t_usb;
    t_out;
    close_out;
  end
endmodule : clock_source_pll_control_tb

// ==== core/ccp_top.sv ====
// Clock source selection, PLL control and clock dividers
// Functional notes
// - After reset the cpu runs from the internal RC oscillator until software changes it.
// - Software picks RC, crystal or RTC oscillator as the PLL input clock.
// - The RC oscillator can clock the watchdog and feed the main PLL; nominal 4 MHz.
// - Crystal (1 to 25 MHz) clocks the cpu directly or via PLL; sole USB PLL source.
// - RTC oscillator can clock the RTC, the main PLL input and the cpu.
// - Cpu clock equals PLL input clock unless the main PLL is active and connected.
// - Each peripheral has its own clock divider off the cpu clock.
// - Main PLL pre-divider N takes every value 1 to 256 before the multiplier.
// - Multiplier M spans 1 to 32768; software keeps the oscillator at 275-550 MHz.
// - Main PLL is off and bypassed on reset and on power-down entry.
// - Only a software write can enable the main PLL.
// - USB PLL takes only the crystal and gives a 48 MHz 50 % clock to USB.
// - USB PLL is off after reset until software enables it.
// - While the USB PLL is off, USB gets 48 MHz derived from the main PLL.
// - One selectable clock goes to the output pin: cpu, RC, crystal, RTC or USB.
// - RTC counting logic gets 1 Hz derived from the 32 kHz RTC oscillator.
`timescale 1ns/10ps

// Edge-counting divider: the output toggles every div edges of clk_in
module ccp_div #(
  parameter int W = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic run,
  input wire logic clk_in,
  input wire logic [W-1:0] div,
  output logic clk_div
);
  logic prev;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  assign next_cnt = cnt + 1'b1;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= clk_in;
    end
  end

  // A divide value of zero acts as one
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      clk_div <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt <= '0;
        clk_div <= 1'b0;
      end else if (clk_in ^ prev) begin
        if (next_cnt >= div) begin
          cnt <= '0;
          clk_div <= !clk_div;
        end else begin
          cnt <= next_cnt;
        end
      end
    end
  end
endmodule : ccp_div

// Glitch-free clock mux: leaves the old clock only at its low phase
module ccp_gmux #(
  parameter int N = 2,
  parameter int SW = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [SW-1:0] sel,
  input wire logic [N-1:0] clk_in,
  output logic clk_mux,
  output logic busy
);
  logic [SW-1:0] cur;
  // Codes beyond the inputs are ignored rather than stopping the clock
  // Compared as int: a one-bit select would wrap N and never report a switch
  assign busy = (sel != cur) && (int'(sel) < N);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '0;
      clk_mux <= 1'b0;
    end else if (ce) begin
      if (busy) begin
        clk_mux <= clk_mux & clk_in[cur];
        if (!clk_mux && !clk_in[sel]) begin
          cur <= sel;
        end
      end else begin
        clk_mux <= clk_in[cur];
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  mux_no_glitch_a: assert property (busy && !clk_mux |=> !clk_mux)
    else $error("clock rose during source switch");
endmodule : ccp_gmux

module ccp_top #(
  parameter logic [15:0] RTC_DIV = ccp_pkg::RTC_HALF_EDGES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic irc_osc,
  input wire logic main_osc,
  input wire logic rtc_osc,
  input wire logic main_cco,
  input wire logic usb_cco,
  input wire logic main_pll_lock,
  input wire logic usb_pll_lock,
  input wire logic pd_entry,
  output logic main_pll_en,
  output logic [14:0] main_pll_mult,
  output logic main_pll_ref,
  output logic usb_pll_en,
  output logic usb_pll_ref,
  output logic pll_input_clock,
  output logic cpu_clock,
  output logic usb_clock,
  output logic wdt_clk,
  output logic rtc_tick_clk,
  output logic clk_out,
  output logic [ccp_pkg::NPER-1:0] periph_clk
);
  logic [ccp_pkg::NPIN-1:0] pin_s1;
  logic [ccp_pkg::NPIN-1:0] pin_s2;
  logic [1:0] src_sel;
  logic wdt_sel;
  logic pll_conn;
  logic [7:0] pll_n;
  logic [7:0] cpu_div;
  logic usb_conn;
  logic [7:0] usb_div;
  logic [2:0] clko_sel;
  logic clko_en;
  logic clko_gate;
  logic [15:0] pclk_sel;
  logic pll_eff;
  logic usb_eff;
  logic main_lock;
  logic usb_lock;
  logic cco_div;
  logic usb48_main;
  logic clko_mux;
  logic cpu_busy;
  logic usb_busy;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (ce) begin
      pin_s1 <= {pd_entry, usb_pll_lock, main_pll_lock, usb_cco, main_cco, rtc_osc, main_osc, irc_osc};
      pin_s2 <= pin_s1;
    end
  end

  assign pll_eff = main_pll_en & pll_conn;
  assign usb_eff = usb_pll_en & usb_conn;
  assign main_lock = main_pll_en & pin_s2[ccp_pkg::PIN_LOCK];
  assign usb_lock = usb_pll_en & pin_s2[ccp_pkg::PIN_ULOCK];

  // Source and watchdog selection; reset lands on the RC oscillator
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      src_sel <= ccp_pkg::SRC_IRC;
      wdt_sel <= 1'b0;
    end else if (ce && wr && addr == ccp_pkg::ADDR_SRC) begin
      src_sel <= wdata[ccp_pkg::SRC_LSB +: 2];
      wdt_sel <= wdata[ccp_pkg::WDT_BIT];
    end
  end

  // Power-down wins over a write in the same cycle so the PLL stays off
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      main_pll_en <= 1'b0;
      pll_conn <= 1'b0;
    end else if (ce) begin
      if (pin_s2[ccp_pkg::PIN_PD]) begin
        main_pll_en <= 1'b0;
        pll_conn <= 1'b0;
      end else if (wr && addr == ccp_pkg::ADDR_PLL_CTRL) begin
        main_pll_en <= wdata[ccp_pkg::EN_BIT];
        pll_conn <= wdata[ccp_pkg::CONN_BIT];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_n <= ccp_pkg::PLL_N_RST;
      main_pll_mult <= ccp_pkg::PLL_M_RST;
    end else if (ce && wr && addr == ccp_pkg::ADDR_PLL_CFG) begin
      pll_n <= wdata[ccp_pkg::CFG_N_LSB +: 8];
      main_pll_mult <= wdata[ccp_pkg::CFG_M_LSB +: 15];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_div <= ccp_pkg::CPU_DIV_RST;
      usb_div <= ccp_pkg::USB_DIV_RST;
      pclk_sel <= ccp_pkg::PCLK_RST;
    end else if (ce && wr) begin
      if (addr == ccp_pkg::ADDR_CPU_DIV) begin
        cpu_div <= wdata[7:0];
      end
      if (addr == ccp_pkg::ADDR_USB_DIV) begin
        usb_div <= wdata[7:0];
      end
      if (addr == ccp_pkg::ADDR_PCLK) begin
        pclk_sel <= wdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      usb_pll_en <= 1'b0;
      usb_conn <= 1'b0;
    end else if (ce && wr && addr == ccp_pkg::ADDR_USB_CTRL) begin
      usb_pll_en <= wdata[ccp_pkg::EN_BIT];
      usb_conn <= wdata[ccp_pkg::CONN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clko_sel <= '0;
      clko_en <= 1'b0;
    end else if (ce && wr && addr == ccp_pkg::ADDR_CLKOUT) begin
      clko_sel <= wdata[ccp_pkg::CLKO_SEL_LSB +: 3];
      clko_en <= wdata[ccp_pkg::CLKO_EN_BIT];
    end
  end

  // The crystal reaches the USB PLL only while it is enabled
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      usb_pll_ref <= 1'b0;
    end else if (ce) begin
      usb_pll_ref <= pin_s2[ccp_pkg::PIN_MAIN] & usb_pll_en;
    end
  end

  // Pin gate changes only while the muxed clock is low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clko_gate <= 1'b0;
      clk_out <= 1'b0;
    end else if (ce) begin
      if (!clko_mux) begin
        clko_gate <= clko_en;
      end
      clk_out <= clko_mux & clko_gate;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          ccp_pkg::ADDR_SRC: rdata <= {29'h0, wdt_sel, src_sel};
          ccp_pkg::ADDR_PLL_CTRL: rdata <= {30'h0, pll_conn, main_pll_en};
          ccp_pkg::ADDR_PLL_CFG: rdata <= {9'h0, main_pll_mult, pll_n};
          ccp_pkg::ADDR_CPU_DIV: rdata <= {24'h0, cpu_div};
          ccp_pkg::ADDR_USB_CTRL: rdata <= {30'h0, usb_conn, usb_pll_en};
          ccp_pkg::ADDR_STATUS: rdata <= {25'h0, cpu_busy, usb_conn, usb_pll_en, usb_lock,
                                          pll_conn, main_pll_en, main_lock};
          ccp_pkg::ADDR_CLKOUT: rdata <= {28'h0, clko_en, clko_sel};
          ccp_pkg::ADDR_USB_DIV: rdata <= {24'h0, usb_div};
          ccp_pkg::ADDR_PCLK: rdata <= {16'h0, pclk_sel};
          default: rdata <= '0;
        endcase
      end
    end
  end

  // Code 3 is ignored, so the previous source stays selected
  ccp_gmux #(.N(3), .SW(2)) u_src_mux (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .sel(src_sel),
    .clk_in({pin_s2[ccp_pkg::PIN_RTC], pin_s2[ccp_pkg::PIN_MAIN], pin_s2[ccp_pkg::PIN_IRC]}),
    .clk_mux(pll_input_clock), .busy()
  );

  // Reference toward the phase detector: input clock divided by N
  ccp_div #(.W(16)) u_pre_div (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .run(main_pll_en),
    .clk_in(pll_input_clock), .div(16'(pll_n) + 16'h0001),
    .clk_div(main_pll_ref)
  );

  ccp_div #(.W(16)) u_cpu_div (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .run(main_pll_en),
    .clk_in(pin_s2[ccp_pkg::PIN_CCO]), .div(16'(cpu_div) + 16'h0001),
    .clk_div(cco_div)
  );

  ccp_gmux #(.N(2), .SW(1)) u_cpu_mux (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .sel(pll_eff),
    .clk_in({cco_div, pll_input_clock}),
    .clk_mux(cpu_clock), .busy(cpu_busy)
  );

  ccp_div #(.W(16)) u_usb_div (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .run(main_pll_en),
    .clk_in(pin_s2[ccp_pkg::PIN_CCO]), .div(16'(usb_div) + 16'h0001),
    .clk_div(usb48_main)
  );

  ccp_gmux #(.N(2), .SW(1)) u_usb_mux (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .sel(usb_eff),
    .clk_in({pin_s2[ccp_pkg::PIN_UCCO], usb48_main}),
    .clk_mux(usb_clock), .busy(usb_busy)
  );

  ccp_gmux #(.N(2), .SW(1)) u_wdt_mux (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .sel(wdt_sel),
    .clk_in({pin_s2[ccp_pkg::PIN_RTC], pin_s2[ccp_pkg::PIN_IRC]}),
    .clk_mux(wdt_clk), .busy()
  );

  ccp_gmux #(.N(5), .SW(3)) u_clko_mux (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .sel(clko_sel),
    .clk_in({usb_clock, pin_s2[ccp_pkg::PIN_RTC], pin_s2[ccp_pkg::PIN_MAIN],
             pin_s2[ccp_pkg::PIN_IRC], cpu_clock}),
    .clk_mux(clko_mux), .busy()
  );

  ccp_div #(.W(16)) u_rtc_div (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .run(1'b1),
    .clk_in(pin_s2[ccp_pkg::PIN_RTC]), .div(RTC_DIV),
    .clk_div(rtc_tick_clk)
  );

  // Divide by 1, 2, 4 or 8, two select bits per peripheral
  for (genvar g = 0; g < ccp_pkg::NPER; g++) begin : g_pclk
    ccp_div #(.W(16)) u_pdiv (
      .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .run(1'b1),
      .clk_in(cpu_clock), .div(16'h0001 << pclk_sel[2*g +: 2]),
      .clk_div(periph_clk[g])
    );
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence rd_status_s;
    ce && rd && addr == ccp_pkg::ADDR_STATUS;
  endsequence

  src_hold_a: assert property (ce && !(wr && addr == ccp_pkg::ADDR_SRC) |=> $stable(src_sel))
    else $error("source select changed without a write");
  pd_pll_off_a: assert property (ce && pin_s2[ccp_pkg::PIN_PD] |=> !main_pll_en && !pll_conn)
    else $error("main pll not off after power-down");
  pll_sw_en_a: assert property ($rose(main_pll_en) |-> $past(wr && addr == ccp_pkg::ADDR_PLL_CTRL))
    else $error("main pll enabled without a write");
  cpu_bypass_a: assert property (ce && !pll_eff && !cpu_busy |=> cpu_clock == $past(pll_input_clock))
    else $error("cpu clock not following pll input");
  usb_ref_a: assert property (ce |=> usb_pll_ref == $past(pin_s2[ccp_pkg::PIN_MAIN] && usb_pll_en))
    else $error("usb pll reference wrong");
  usb_sw_en_a: assert property ($rose(usb_pll_en) |-> $past(wr && addr == ccp_pkg::ADDR_USB_CTRL))
    else $error("usb pll enabled without a write");
  usb_fallback_a: assert property (ce && !usb_eff && !usb_busy |=> usb_clock == $past(usb48_main))
    else $error("usb clock not from main pll path");
  status_lock_a: assert property (rd_status_s |=> rdata[0] == $past(main_lock))
    else $error("status lock bit wrong");
endmodule : ccp_top

// ==== include/ccp_pkg.sv ====
// Constants of the clock source and PLL control block
package ccp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_SRC = 8'h00;
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PLL_CFG = 8'h08;
  localparam logic [7:0] ADDR_CPU_DIV = 8'h0c;
  localparam logic [7:0] ADDR_USB_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CLKOUT = 8'h18;
  localparam logic [7:0] ADDR_USB_DIV = 8'h1c;
  localparam logic [7:0] ADDR_PCLK = 8'h20;
  // Field positions
  localparam int SRC_LSB = 0;
  localparam int WDT_BIT = 2;
  localparam int EN_BIT = 0;
  localparam int CONN_BIT = 1;
  localparam int CFG_N_LSB = 0;
  localparam int CFG_M_LSB = 8;
  localparam int CLKO_SEL_LSB = 0;
  localparam int CLKO_EN_BIT = 3;
  // Source codes
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  // Reset values
  localparam logic [7:0] CPU_DIV_RST = 8'h00;
  localparam logic [7:0] USB_DIV_RST = 8'h05;
  localparam logic [7:0] PLL_N_RST = 8'h00;
  localparam logic [14:0] PLL_M_RST = 15'h0000;
  localparam logic [15:0] PCLK_RST = 16'h0000;
  // Pin synchroniser indices
  localparam int PIN_IRC = 0;
  localparam int PIN_MAIN = 1;
  localparam int PIN_RTC = 2;
  localparam int PIN_CCO = 3;
  localparam int PIN_UCCO = 4;
  localparam int PIN_LOCK = 5;
  localparam int PIN_ULOCK = 6;
  localparam int PIN_PD = 7;
  localparam int NPIN = 8;
  localparam int NPER = 8;
  // Timing: the RTC tick comes from the RTC oscillator
  localparam int RTC_OSC_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam logic [15:0] RTC_HALF_EDGES = 16'(RTC_OSC_HZ / RTC_TICK_HZ);
endpackage : ccp_pkg
